// >>> hdl/lfw_lcd_frame.sv
// Overview of operation
// RULE1: Net DC on every pixel averages zero
// RULE2: Dark pixels high rms, clear low rms
// RULE3: Per-frame type inverts within each slice
// RULE4: Two-frame type inverts at frame boundary
// RULE5: Divided oscillator source always sleeps with core
// RULE6: Software sleeps only at zero DC
// RULE7: Common zero leading edge starts frame
// RULE8: Interrupt right after frame data fetch
// RULE9: Interrupt leads boundary; fetch follows window
// RULE10: Software writes within window after interrupt
// RULE11: Two-frame data constant across frame pair
// RULE12: Two-frame updates only after interrupt
// RULE13: Two-frame interrupt once per frame pair
// RULE14: Blocked pixel write discarded, sets error
// RULE15: No interrupt per-frame type or static
// RULE16: Common zero uses registers twelve to fourteen
// RULE17: Common one uses registers fifteen to seventeen
// RULE18: Common two uses registers eighteen to twenty
// RULE19: Common three uses registers twenty-one to twenty-three
// RULE20: Sleep stop drives minimum voltage immediately
// RULE21: Disable waits for frame end, releases pins; code still drives all pins low while sleep_stop is set, even when idle
// RULE22: Flags stay set until software clears
// RULE23: Writes accepted always except two-frame outside window
`timescale 1ns/1ns
`default_nettype none
module lfw_lcd_frame
    import lfw_pkg::*;
(
    input wire logic CLK, // System clock
    input wire logic RST, // Async reset, active high
    input wire logic CE, // Clock enable
    input wire logic PSEL, // APB select
    input wire logic PENABLE, // APB enable
    input wire logic PWRITE, // APB direction
    input wire logic [7:0] PADDR, // APB byte address
    input wire logic [31:0] PWDATA, // APB write data
    output logic [31:0] PRDATA, // APB read data
    output logic PREADY, // APB ready
    output logic PSLVERR, // APB error
    input wire logic CORE_SLEEP, // Core in sleep
    output logic FRAME_IRQ, // Frame interrupt flag
    output lfw_drive_t DRIVE // Common/segment drive
);

    typedef enum {ST_IDLE, ST_RUN, ST_STOPPING} lfw_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0] ctrl;
    logic [7:0] pix [NUM_PIX_REGS];
    logic frame_flag;
    lfw_state_t state;
    logic [6:0] slice_cnt;
    logic [1:0] com_idx;
    logic phase;
    logic pair_odd;
    logic win_open;
    logic slept;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    wire [1:0] mux_sel = ctrl[CTRL_MUX_LSB +: 2];
    wire [1:0] src_sel = ctrl[CTRL_SRC_LSB +: 2];
    wire type_b = ctrl[CTRL_WFB_BIT];
    wire mod_en = ctrl[CTRL_EN_BIT];
    wire sleep_stop = CORE_SLEEP && (ctrl[CTRL_SLP_BIT] || src_sel == SRC_OSC8192); // RULE5
    wire running = (state != ST_IDLE) && !slept;
    wire [1:0] last_com = mux_sel;
    wire wr_phase = PSEL && PENABLE && PWRITE && CE;
    wire [7:0] pix_off = PADDR - ADDR_PIX_BASE;
    wire pix_hit = (PADDR >= ADDR_PIX_BASE) && (pix_off[7:2] < 6'(NUM_PIX_REGS)) && (PADDR[1:0] == 2'h0);
    wire [3:0] pix_idx = pix_off[5:2];
    wire ctrl_hit = PADDR == ADDR_CTRL;
    wire stat_hit = PADDR == ADDR_STATUS;
    wire mapped = pix_hit || ctrl_hit || stat_hit;
    wire irq_mode = type_b && (mux_sel != MUX_STATIC); // RULE15
    wire writes_ok = !irq_mode || win_open || !running; // RULE23
    wire pix_wr = wr_phase && pix_hit && writes_ok;
    wire pix_blocked = wr_phase && pix_hit && !writes_ok; // RULE14
    wire slice_end = slice_cnt == 7'(SLICE_CYCLES - 1);
    wire frame_end = slice_end && (com_idx == last_com);
    // Fetch of the last slice's data completes FETCH_CYCLES into it
    wire fetch_done = (com_idx == last_com) && slice_cnt == 7'(FETCH_CYCLES - 1); // RULE8
    wire pair_done = fetch_done && pair_odd; // RULE13
    wire set_irq = running && irq_mode && pair_done; // RULE9
    wire ctrl_wr = wr_phase && ctrl_hit;

    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign FRAME_IRQ = frame_flag;

    ////////////////////////////////////////////////////////////////////////
    // Control register; error flag set beats clear
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl <= CTRL_RESET;
        end else if (CE) begin
            if (ctrl_wr) begin
                ctrl <= PWDATA[7:0] & ~(8'h01 << CTRL_WRITE_ERROR_FLAG_BIT);
            end
            if (pix_blocked || (ctrl[CTRL_WRITE_ERROR_FLAG_BIT] && !(ctrl_wr && !PWDATA[CTRL_WRITE_ERROR_FLAG_BIT]))) begin
                ctrl[CTRL_WRITE_ERROR_FLAG_BIT] <= 1'b1; // RULE14 RULE22
            end
        end
    end

    // Status: frame flag, write one to clear, set wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            frame_flag <= 1'b0;
        end else if (CE) begin
            if (set_irq) begin
                frame_flag <= 1'b1; // RULE22
            end else if (wr_phase && stat_hit && PWDATA[STAT_FIF_BIT]) begin
                frame_flag <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pixel registers
    generate
        for (genvar r = 0; r < NUM_PIX_REGS; r++) begin : g_pix
            always_ff @(posedge CLK or posedge RST) begin
                if (RST) begin
                    pix[r] <= PIX_RESET;
                end else if (CE && pix_wr && pix_idx == 4'(r)) begin
                    pix[r] <= PWDATA[7:0]; // RULE14
                end
            end
        end
    endgenerate

    // Read mux
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            PRDATA <= 32'h0;
        end else if (CE) begin
            if (PSEL && !PENABLE && !PWRITE) begin
                if (ctrl_hit) begin
                    PRDATA <= {24'h0, ctrl};
                end else if (stat_hit) begin
                    PRDATA <= {29'h0, phase, running, frame_flag};
                end else if (pix_hit) begin
                    PRDATA <= {24'h0, pix[pix_idx]};
                end else begin
                    PRDATA <= 32'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Frame sequencer
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            state <= ST_IDLE;
            slice_cnt <= 7'h0;
            com_idx <= 2'h0;
            phase <= 1'b0;
            pair_odd <= 1'b0;
            win_open <= 1'b0;
            slept <= 1'b0;
        end else if (CE) begin
            slept <= sleep_stop && state != ST_IDLE; // RULE20
            if (state == ST_IDLE || sleep_stop) begin
                slice_cnt <= 7'h0;
                com_idx <= 2'h0; // RULE7
                win_open <= 1'b0;
                if (state == ST_IDLE && mod_en && !sleep_stop) begin
                    state <= ST_RUN;
                end
            end else begin
                slice_cnt <= slice_end ? 7'h0 : slice_cnt + 7'h1;
                if (set_irq) begin
                    win_open <= 1'b1;
                end else if (fetch_done && !pair_odd) begin
                    win_open <= 1'b0; // RULE10 RULE12
                end
                if (state == ST_RUN && !mod_en) begin
                    state <= ST_STOPPING;
                end
                if (slice_end) begin
                    com_idx <= frame_end ? 2'h0 : com_idx + 2'h1; // RULE7
                end
                if (frame_end) begin
                    phase <= ~phase; // RULE4
                    pair_odd <= ~pair_odd; // RULE11
                    if (state == ST_STOPPING || !mod_en) begin
                        state <= ST_IDLE; // RULE21
                        phase <= 1'b0;
                        pair_odd <= 1'b0;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Drive generation: level is 1 for the active polarity
    // Second half of each slice carries the inverted phase for the per-frame type
    wire sub_half = slice_cnt >= 7'(SLICE_CYCLES / 2); // RULE3
    wire pol = type_b ? phase : sub_half; // RULE3 RULE4
    logic [NUM_SEGS-1:0] seg_bits;
    always_comb begin
        seg_bits = {pix[com_idx*3 + 2][1:0], pix[com_idx*3 + 1], pix[com_idx*3]}; // RULE16 RULE17 RULE18 RULE19
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            DRIVE <= '0;
        end else if (CE) begin
            if (!running || sleep_stop) begin
                DRIVE.com_level <= '0; // RULE20
                DRIVE.seg_level <= '0;
                DRIVE.com_oe <= {NUM_COMS{running || sleep_stop}};
                DRIVE.seg_oe <= {NUM_SEGS{running || sleep_stop}};
            end else begin
                for (int c = 0; c < NUM_COMS; c++) begin
                    DRIVE.com_level[c] <= (2'(c) == com_idx) ? pol : ~pol; // RULE1
                    DRIVE.com_oe[c] <= 2'(c) <= last_com;
                end
                // Dark segment opposes the active common, clear follows it
                DRIVE.seg_level <= seg_bits ^ {NUM_SEGS{pol}}; // RULE2 RULE1
                DRIVE.seg_oe <= '1;
            end
        end
    end

endmodule : lfw_lcd_frame
`default_nettype wire

// >>> hdl/lfw_pkg.sv
package lfw_pkg;
    // Register byte addresses (pixel registers follow the control words)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PIX_BASE = 8'h08;
    localparam int NUM_PIX_REGS = 12;
    localparam int NUM_COMS = 4;
    localparam int NUM_SEGS = 18;
    // Control register fields
    localparam int CTRL_MUX_LSB = 0;
    localparam int CTRL_SRC_LSB = 2;
    localparam int CTRL_WFB_BIT = 4;
    localparam int CTRL_WRITE_ERROR_FLAG_BIT = 5;
    localparam int CTRL_SLP_BIT = 6;
    localparam int CTRL_EN_BIT = 7;
    localparam logic [7:0] CTRL_RESET = 8'h03;
    // Status register fields
    localparam int STAT_FIF_BIT = 0;
    localparam int STAT_ACT_BIT = 1;
    localparam int STAT_PHASE_BIT = 2;
    localparam logic [1:0] SRC_OSC8192 = 2'h0;
    localparam logic [1:0] MUX_STATIC = 2'h0;
    // Slice timing in clock cycles
    localparam int SLICE_CYCLES = 64;
    localparam int FETCH_CYCLES = 4;
    localparam logic [7:0] PIX_RESET = 8'h00;

    typedef struct packed {
        logic [NUM_COMS-1:0] com_level;
        logic [NUM_COMS-1:0] com_oe;
        logic [NUM_SEGS-1:0] seg_level;
        logic [NUM_SEGS-1:0] seg_oe;
    } lfw_drive_t;
endpackage : lfw_pkg

// >>> sim/lfw_lcd_frame_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, s); end end
module lfw_lcd_frame_bench
    import lfw_pkg::*;
;
    logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, CORE_SLEEP = 0, PREADY, PSLVERR, FRAME_IRQ, slv;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic [7:0] pix [NUM_PIX_REGS];
    lfw_drive_t DRIVE;
    int err_count = 0, comparisons = 0, cyc = 0, seed = 32'h3cd6, dc, t0;
    always #5 CLK = ~CLK;
    lfw_lcd_frame i_dut (.CLK(CLK), .RST(RST), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .CORE_SLEEP(CORE_SLEEP), .FRAME_IRQ(FRAME_IRQ), .DRIVE(DRIVE));
    lfw_panel i_panel (.CLK(CLK), .DRIVE(DRIVE), .dc(dc));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do @(posedge CLK); while (PREADY !== 1'b1);
        rd = PRDATA;
        slv = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb
    task automatic wirq;
        int n;
        n = 0;
        while (FRAME_IRQ !== 1'b1 && n < 2000) begin
            @(posedge CLK);
            n++;
        end
        `CHK("frame flag", 1'b1, FRAME_IRQ)
    endtask : wirq
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            end_of_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl reset", {24'h0, CTRL_RESET}, rd)
        for (int k = 0; k < NUM_PIX_REGS; k++) begin
            pix[k] = $random(seed);
            apb(1'b1, ADDR_PIX_BASE + 8'(4 * k), {24'h0, pix[k]});
        end
        for (int k = 0; k < NUM_PIX_REGS; k++) begin
            apb(1'b0, ADDR_PIX_BASE + 8'(4 * k), 32'h0);
            `CHK("pixel", {24'h0, pix[k]}, rd)
        end
        apb(1'b1, 8'h40, 32'hff);
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        `CHK("unmapped error", 1'b1, slv)
        apb(1'b1, ADDR_CTRL, 32'h80);
        repeat (70) @(posedge CLK);
        `CHK("segments", {pix[2][1:0], pix[1], pix[0]} ^ {NUM_SEGS{DRIVE.com_level[0]}}, DRIVE.seg_level)
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, ADDR_CTRL, {24'h0, 3'b100, m[2], 2'b01, m[1:0]});
            apb(1'b1, ADDR_STATUS, 32'h1);
            repeat (600) @(posedge CLK);
            `CHK("frame flag", m[2] && m[1:0] != 2'b00, FRAME_IRQ)
        end
        apb(1'b1, ADDR_STATUS, 32'h1);
        wirq;
        t0 = cyc;
        apb(1'b1, ADDR_STATUS, 32'h1);
        `CHK("flag clear", 1'b0, FRAME_IRQ)
        pix[0] = $random(seed);
        apb(1'b1, ADDR_PIX_BASE, {24'h0, pix[0]});
        repeat (300) @(posedge CLK);
        apb(1'b1, ADDR_PIX_BASE, {24'h0, ~pix[0]});
        apb(1'b0, ADDR_PIX_BASE, 32'h0);
        `CHK("pixel", {24'h0, pix[0]}, rd)
        wirq;
        `CHK("pair period", 2 * NUM_COMS * SLICE_CYCLES, cyc - t0)
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("write error", 1'b1, rd[CTRL_WRITE_ERROR_FLAG_BIT])
        apb(1'b1, ADDR_CTRL, 32'h97);
        apb(1'b0, ADDR_CTRL, 32'h0);
        `CHK("ctrl", 32'h97, rd)
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, ADDR_CTRL, k ? 32'h93 : 32'hd7);
            CORE_SLEEP <= 1'b1;
            repeat (3) @(posedge CLK);
            `CHK("sleep drive", 22'h0, {DRIVE.com_level, DRIVE.seg_level})
            CORE_SLEEP <= 1'b0;
            @(posedge CLK);
        end
        apb(1'b1, ADDR_CTRL, 32'h0);
        repeat (300) @(posedge CLK);
        `CHK("pins released", 22'h0, {DRIVE.com_oe, DRIVE.seg_oe})
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("active", 1'b0, rd[STAT_ACT_BIT])
        end_of_test;
    end
endmodule : lfw_lcd_frame_bench
`default_nettype wire

// >>> sim/lfw_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module lfw_monitor
    import lfw_pkg::*;
(
    input wire logic CLK, // Clock
    input wire logic RST, // Reset
    input wire logic CE, // Clock enable
    input wire logic PSEL, // Select
    input wire logic PENABLE, // Enable
    input wire logic PWRITE, // Direction
    input wire logic [7:0] PADDR, // Address
    input wire logic [31:0] PWDATA, // Write data
    input wire logic [31:0] PRDATA, // Read data
    input wire logic PREADY, // Ready
    input wire logic PSLVERR, // Error
    input wire logic CORE_SLEEP, // Core sleep
    input wire logic FRAME_IRQ, // Frame flag
    input wire lfw_drive_t DRIVE // Pin drive
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    logic [7:0] ctl;
    wire logic wr = PSEL && PENABLE && PWRITE && CE;
    wire logic b_irq = ctl[CTRL_WFB_BIT] && ctl[1:0] != MUX_STATIC;
    wire logic slp = CORE_SLEEP && (ctl[CTRL_SLP_BIT] || ctl[3:2] == SRC_OSC8192);
    wire logic fclr = wr && PADDR == ADDR_STATUS && PWDATA[STAT_FIF_BIT];
    // Shadow of the control word as software wrote it
    always_ff @(posedge CLK or posedge RST)
        if (RST) ctl <= CTRL_RESET;
        else if (wr && PADDR == ADDR_CTRL) ctl <= PWDATA[7:0];
    a_no_irq_mode: assert property ((!b_irq) [*2] |=> !$rose(FRAME_IRQ))
        else $error("frame flag rose outside two-frame multiplex");
    a_irq_holds: assert property (FRAME_IRQ && !fclr |=> FRAME_IRQ)
        else $error("frame flag dropped without a clear");
    a_sleep_quiet: assert property (slp |-> ##[1:2] (DRIVE.com_level == '0 && DRIVE.seg_level == '0))
        else $error("lines not at minimum level in sleep");
    a_sleep_frozen: assert property ((slp) [*3] |-> $stable(DRIVE))
        else $error("drive moved while asleep");
    a_idle_release: assert property (!ctl[CTRL_EN_BIT] |-> ##[0:300] (DRIVE.com_oe == '0 && DRIVE.seg_oe == '0))
        else $error("pins still driven after disable");
    a_type_a_flip: assert property ((ctl[CTRL_EN_BIT] && !ctl[CTRL_WFB_BIT] && !slp) [*2]
        |-> ##[1:64] $changed(DRIVE.com_level))
        else $error("no phase inversion within a slice");
    a_slverr_map: assert property (PSEL && PENABLE |-> PSLVERR == (PADDR > 8'h34 || PADDR[1:0] != 2'h0))
        else $error("error response does not match the map");
    a_ready_high: assert property (PSEL && PENABLE |-> PREADY)
        else $error("access phase stalled");
    c_irq: cover property ($rose(FRAME_IRQ));
    c_sleep: cover property (slp);
    c_slverr: cover property (PSLVERR);
endmodule : lfw_monitor
bind lfw_lcd_frame lfw_monitor i_mon (.CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CORE_SLEEP(CORE_SLEEP), .FRAME_IRQ(FRAME_IRQ), .DRIVE(DRIVE));
`default_nettype wire

// >>> sim/lfw_panel.sv
`timescale 1ns/1ns
`default_nettype none
module lfw_panel
    import lfw_pkg::*;
(
    input wire logic CLK, // Clock
    input wire lfw_drive_t DRIVE, // Pin drive
    output int dc // Net charge of the first pixel
);
    initial dc = 0;
    // Passive glass: charge builds only while both lines drive
    always @(posedge CLK)
        if (DRIVE.com_oe[0] && DRIVE.seg_oe[0])
            dc <= dc + int'(DRIVE.com_level[0]) - int'(DRIVE.seg_level[0]);
endmodule : lfw_panel
`default_nettype wire
